// file: src/l1cm_pkg.sv
// constants and types of the l1 cache maintenance controller
package l1cm_pkg;
  localparam logic [11:0] OFS_IC_INV_ALL = 12'h000;
  localparam logic [11:0] OFS_IC_INV_ADDR = 12'h004;
  localparam logic [11:0] OFS_DC_INV_ADDR = 12'h008;
  localparam logic [11:0] OFS_DC_INV_SW = 12'h00c;
  localparam logic [11:0] OFS_DC_CLN_UNIF = 12'h010;
  localparam logic [11:0] OFS_DC_CLN_COH = 12'h014;
  localparam logic [11:0] OFS_DC_CLN_SW = 12'h018;
  localparam logic [11:0] OFS_DC_CI_ADDR = 12'h01c;
  localparam logic [11:0] OFS_DC_CI_SW = 12'h020;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_RET = 2'h1;
  localparam logic [1:0] PWR_ON = 2'h2;
  localparam int SH_SHARED_BIT = 1;
  localparam int I_WAYS = 2;
  localparam int D_WAYS = 4;
  localparam int NUM_SETS = 1024;
  typedef enum logic [3:0] {
    op_none = 4'h0,
    icache_invalidate_all_op = 4'h1,
    icache_invalidate_by_addr_op = 4'h2,
    dcache_invalidate_by_addr_op = 4'h3,
    dcache_invalidate_setway_op = 4'h4,
    dcache_clean_addr_unif_op = 4'h5,
    dcache_clean_addr_coh_op = 4'h6,
    dcache_clean_setway_op = 4'h7,
    dcache_clean_inval_addr_op = 4'h8,
    dcache_clean_inval_setway_op = 4'h9
  } l1cm_op_t;
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_op = 1'b1
  } l1cm_st_t;
endpackage

// file: src/l1cm_if.sv
// links the controller with its sweep counter and operation decoder
`timescale 1ns/1ps
interface l1cm_if #(parameter int IDX_W = 10);
  import l1cm_pkg::*;
  logic start;
  logic skip;
  logic busy;
  logic done;
  logic [IDX_W-1:0] idx;
  logic [11:0] ofs;
  logic ns;
  l1cm_op_t op;
  logic hit;
  modport ctrl(output start, skip, ofs, ns, input busy, done, idx, op, hit);
  modport sweep(input start, skip, output busy, done, idx);
  modport dec(input ofs, ns, output op, hit);
endinterface

// file: src/l1cm_decode.sv
// maps a store offset to a maintenance operation, with non-secure promotion
`timescale 1ns/1ps
module l1cm_decode #(
  parameter bit SEC_EXT = 1'b1
) (
  l1cm_if.dec bus // offset in, operation out
);
  import l1cm_pkg::*;
  always_comb begin
    bus.hit = 1'b1;
    case (bus.ofs)
      OFS_IC_INV_ALL: bus.op = icache_invalidate_all_op;
      OFS_IC_INV_ADDR: bus.op = icache_invalidate_by_addr_op;
      OFS_DC_INV_ADDR: begin
        if (SEC_EXT && bus.ns) bus.op = dcache_clean_inval_addr_op;
        else bus.op = dcache_invalidate_by_addr_op;
      end
      OFS_DC_INV_SW: begin
        if (SEC_EXT && bus.ns) bus.op = dcache_clean_inval_setway_op;
        else bus.op = dcache_invalidate_setway_op;
      end
      OFS_DC_CLN_UNIF: bus.op = dcache_clean_addr_unif_op;
      OFS_DC_CLN_COH: bus.op = dcache_clean_addr_coh_op;
      OFS_DC_CLN_SW: bus.op = dcache_clean_setway_op;
      OFS_DC_CI_ADDR: bus.op = dcache_clean_inval_addr_op;
      OFS_DC_CI_SW: bus.op = dcache_clean_inval_setway_op;
      default: begin
        bus.op = op_none;
        bus.hit = 1'b0;
      end
    endcase
  end
endmodule // l1cm_decode

// file: src/l1cm_sweep.sv
// power-up invalidation index counter
`timescale 1ns/1ps
module l1cm_sweep #(
  parameter int SETS = l1cm_pkg::NUM_SETS,
  parameter int IDX_W = $clog2(SETS)
) (
  input wire logic clk, // core clock
  input wire logic resetn, // synchronous, active low
  l1cm_if.sweep bus // start, busy, done, index
);
  import l1cm_pkg::*;
  localparam logic [IDX_W-1:0] LAST = IDX_W'(SETS - 1);
  typedef struct packed {
    logic busy;
    logic done;
    logic [IDX_W-1:0] idx;
  } l1cm_sw_t;
  l1cm_sw_t s;
  l1cm_sw_t next_s;
  always_comb begin
    next_s = s;
    if (bus.start) begin
      next_s.busy = 1'b1;
      next_s.done = 1'b0;
      next_s.idx = '0;
    end else if (bus.skip) begin
      next_s.done = 1'b1;
    end else if (s.busy) begin
      if (s.idx == LAST) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.idx = s.idx + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) s <= '0;
    else s <= next_s;
  end
  assign bus.busy = s.busy;
  assign bus.done = s.done;
  assign bus.idx = s.idx;
  AST_SWEEP_STEP: assert property (@(posedge clk) disable iff (!resetn)
    s.busy && s.idx != LAST && !bus.start |=> s.busy && s.idx == $past(s.idx) + 1'b1)
    else $error("sweep index did not advance by one");
  AST_SWEEP_END: assert property (@(posedge clk) disable iff (!resetn)
    s.busy && s.idx == LAST && !bus.start |=> s.done && !s.busy)
    else $error("sweep did not finish after the last index");
  CV_SWEEP_END: cover property (@(posedge clk) disable iff (!resetn) s.busy ##1 s.done);
endmodule // l1cm_sweep

// file: src/l1cm_ctrl.sv
// l1 cache maintenance and access gating controller
`timescale 1ns/1ps
module l1cm_ctrl #(
  parameter bit SEC_EXT = 1'b1, // security extension present
  parameter bit UNIFIED = 1'b0, // data side cache is a unified cache
  parameter int SETS = l1cm_pkg::NUM_SETS, // indexes to sweep
  parameter int IDX_W = $clog2(SETS)
) (
  input wire logic I_CLK, // core clock
  input wire logic I_RESETN, // synchronous reset, active low
  input wire logic I_AUTO_INV_DIS, // auto invalidate disable strap
  input wire logic I_CORE_PWR_ON, // core power domain on
  input wire logic [1:0] I_RAM_PWR, // ram power domain off, ret, on
  input wire logic I_MNT_VALID, // maintenance store valid
  input wire logic [11:0] I_MNT_OFS, // store offset in private space
  input wire logic [1:0] I_MNT_SIZE, // store size code
  input wire logic [31:0] I_MNT_WDATA, // address or set/way word
  input wire logic I_MNT_NS, // store issued from non-secure state
  output logic O_MNT_READY, // store may be taken
  output logic O_MNT_ERR, // store unmapped or not a word
  output logic O_OP_VALID, // operation to cache rams
  output l1cm_pkg::l1cm_op_t O_OP_CODE, // operation code
  output logic O_OP_ICACHE, // targets instruction cache
  output logic [31:0] O_OP_ARG, // operation argument
  input wire logic I_OP_DONE, // cache rams finished operation
  input wire logic I_DSB_REQ, // barrier wants completion
  input wire logic I_DSB_ABORT, // exception aborts barrier wait
  output logic O_DSB_STALL, // barrier waiting
  output logic O_DSB_DONE, // barrier complete
  input wire logic I_DC_EN, // data cache enable bit
  input wire logic I_IC_EN, // instruction cache enable bit
  input wire logic I_DC_ACT, // data cache active bit
  input wire logic I_IC_ACT, // instruction cache active bit
  input wire logic I_ACC_VALID, // data side access valid
  input wire logic I_ACC_FETCH, // access is fetch through unified cache
  input wire logic [1:0] I_ACC_SH, // region shareability field
  input wire logic I_ACC_INNER_C, // programmed inner cacheable
  output logic O_ACC_VALID, // attribute result valid
  output logic O_ACC_CACHEABLE, // access treated as cacheable
  output logic O_D_LOOKUP, // data cache may look up
  output logic O_D_ALLOC, // data cache may allocate
  output logic O_I_LOOKUP, // instruction cache may look up
  output logic O_I_ALLOC, // instruction cache may allocate
  output logic O_INV_VALID, // sweep invalidating this cycle
  output logic [IDX_W-1:0] O_INV_INDEX, // sweep index
  output logic [l1cm_pkg::I_WAYS-1:0] O_INV_I_WAYS, // instruction ways cleared
  output logic [l1cm_pkg::D_WAYS-1:0] O_INV_D_WAYS, // data ways cleared
  output logic O_INV_DONE // sweep done flag
);
  import l1cm_pkg::*;

  typedef struct packed {
    l1cm_st_t st;
    logic rdy;
    logic opv;
    l1cm_op_t op;
    logic op_i;
    logic [31:0] arg;
    logic err;
    logic dsb_wait;
    logic dsb_done;
    logic [1:0] pwr_q;
    logic boot;
    logic start;
    logic skip;
    logic d_lookup;
    logic d_alloc;
    logic i_lookup;
    logic i_alloc;
    logic acc_v;
    logic acc_c;
  } l1cm_ctl_t;

  l1cm_ctl_t s;
  l1cm_ctl_t next_s;
  logic take;
  logic is_i;
  logic busy_any;
  logic ram_on;
  logic use_ok;

  l1cm_if #(.IDX_W(IDX_W)) mif();

  l1cm_decode #(.SEC_EXT(SEC_EXT)) u_dec (
    .bus(mif.dec)
  );

  l1cm_sweep #(.SETS(SETS), .IDX_W(IDX_W)) u_sweep (
    .clk(I_CLK),
    .resetn(I_RESETN),
    .bus(mif.sweep)
  );

  assign mif.ofs = I_MNT_OFS;
  assign mif.ns = I_MNT_NS;
  assign mif.start = s.start;
  assign mif.skip = s.skip;

  assign take = I_MNT_VALID && s.rdy;
  assign is_i = (mif.op == icache_invalidate_all_op) || (mif.op == icache_invalidate_by_addr_op);
  assign ram_on = (I_RAM_PWR == PWR_ON);
  // caches usable only once no sweep is running, pending or being triggered this cycle
  assign use_ok = mif.done && !mif.busy && !s.start && !next_s.start && ram_on;
  // anything the barrier must wait for
  assign busy_any = s.boot || s.start || mif.busy || s.opv;

  always_comb begin
    next_s = s;
    next_s.err = 1'b0;
    next_s.dsb_done = 1'b0;
    next_s.start = 1'b0;
    next_s.skip = 1'b0;
    next_s.pwr_q = I_RAM_PWR;
    // sweep triggers
    if (s.boot) begin
      next_s.boot = 1'b0;
      if (I_AUTO_INV_DIS) next_s.skip = 1'b1;
      else next_s.start = 1'b1;
    end else if (ram_on && s.pwr_q == PWR_OFF && I_CORE_PWR_ON) begin
      next_s.start = 1'b1;
    end
    // maintenance requests
    case (s.st)
      st_idle: begin
        if (take) begin
          if (!mif.hit || I_MNT_SIZE != SIZE_WORD) begin
            next_s.err = 1'b1;
          end else if (!mif.done || s.start || mif.busy) begin
            next_s.op = s.op;
          end else if (is_i ? I_IC_ACT : I_DC_ACT) begin
            next_s.st = st_op;
            next_s.rdy = 1'b0;
            next_s.opv = 1'b1;
            next_s.op = mif.op;
            next_s.op_i = is_i;
            next_s.arg = I_MNT_WDATA;
          end
        end
      end
      st_op: begin
        if (I_OP_DONE) begin
          next_s.st = st_idle;
          next_s.rdy = 1'b1;
          next_s.opv = 1'b0;
        end
      end
      default: begin
        next_s.st = st_idle;
        next_s.rdy = 1'b1;
        next_s.opv = 1'b0;
      end
    endcase
    // barrier
    if (s.dsb_wait) begin
      if (I_DSB_ABORT) begin
        next_s.dsb_wait = 1'b0;
      end else if (!busy_any) begin
        next_s.dsb_wait = 1'b0;
        next_s.dsb_done = 1'b1;
      end
    end else if (I_DSB_REQ) begin
      next_s.dsb_wait = 1'b1;
    end
    // lookup and allocation gating
    next_s.d_lookup = use_ok && I_DC_ACT;
    next_s.d_alloc = use_ok && I_DC_ACT && I_DC_EN;
    next_s.i_lookup = use_ok && I_IC_ACT;
    next_s.i_alloc = use_ok && I_IC_ACT && I_IC_EN;
    // data side cacheability
    next_s.acc_v = I_ACC_VALID;
    if (UNIFIED && I_ACC_FETCH) begin
      next_s.acc_c = I_ACC_VALID && next_s.d_lookup && I_ACC_INNER_C;
    end else begin
      next_s.acc_c = I_ACC_VALID && next_s.d_lookup && I_ACC_INNER_C
        && !I_ACC_SH[SH_SHARED_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      s <= '0;
      s.boot <= 1'b1;
      s.rdy <= 1'b1;
      s.op <= op_none;
      s.st <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign O_MNT_READY = s.rdy;
  assign O_MNT_ERR = s.err;
  assign O_OP_VALID = s.opv;
  assign O_OP_CODE = s.op;
  assign O_OP_ICACHE = s.op_i;
  assign O_OP_ARG = s.arg;
  assign O_DSB_STALL = s.dsb_wait;
  assign O_DSB_DONE = s.dsb_done;
  assign O_ACC_VALID = s.acc_v;
  assign O_ACC_CACHEABLE = s.acc_c;
  assign O_D_LOOKUP = s.d_lookup;
  assign O_D_ALLOC = s.d_alloc;
  assign O_I_LOOKUP = s.i_lookup;
  assign O_I_ALLOC = s.i_alloc;
  assign O_INV_VALID = mif.busy;
  assign O_INV_INDEX = mif.idx;
  assign O_INV_I_WAYS = {I_WAYS{mif.busy}};
  assign O_INV_D_WAYS = {D_WAYS{mif.busy}};
  assign O_INV_DONE = mif.done;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  AST_WORD_ONLY: assert property (
    take && I_MNT_SIZE != SIZE_WORD |=> O_MNT_ERR && !O_OP_VALID)
    else $error("non-word maintenance store was not refused");
  AST_IC_TARGET: assert property (
    O_OP_VALID |-> O_OP_ICACHE == (O_OP_CODE inside {icache_invalidate_all_op,
      icache_invalidate_by_addr_op}))
    else $error("operation routed to the wrong cache");
  AST_NS_SETWAY: assert property (
    take && SEC_EXT && I_MNT_NS && I_MNT_OFS == OFS_DC_INV_SW && I_MNT_SIZE == SIZE_WORD
      && mif.done && !mif.busy && !s.start && I_DC_ACT
      |=> O_OP_VALID && O_OP_CODE == dcache_clean_inval_setway_op)
    else $error("non-secure set/way invalidate not promoted");
  AST_NS_ADDR: assert property (
    take && SEC_EXT && I_MNT_NS && I_MNT_OFS == OFS_DC_INV_ADDR && I_MNT_SIZE == SIZE_WORD
      && mif.done && !mif.busy && !s.start && I_DC_ACT
      |=> O_OP_VALID && O_OP_CODE == dcache_clean_inval_addr_op)
    else $error("non-secure address invalidate not promoted");
  AST_IC_NO_PROMO: assert property (
    take && I_MNT_OFS == OFS_IC_INV_ADDR && I_MNT_SIZE == SIZE_WORD && mif.done
      && !mif.busy && !s.start && I_IC_ACT
      |=> O_OP_CODE == icache_invalidate_by_addr_op && O_OP_ICACHE)
    else $error("instruction invalidate was altered");
  AST_DSB_WAIT: assert property (
    O_DSB_DONE |-> $past(!O_OP_VALID) && $past(!O_INV_VALID) && !O_DSB_STALL)
    else $error("barrier completed with work outstanding");
  AST_PWR_UP: assert property (
    !s.boot && ram_on && s.pwr_q == PWR_OFF && I_CORE_PWR_ON |=> s.start ##1 O_INV_VALID)
    else $error("ram power-up did not start the sweep");
  AST_SWEEP_NOP: assert property (
    O_INV_VALID |-> !O_D_LOOKUP && !O_I_ALLOC ##1 !O_ACC_CACHEABLE)
    else $error("cache used during sweep");
  AST_MNT_NOP: assert property (
    take && O_INV_VALID |=> !O_OP_VALID)
    else $error("maintenance performed during sweep");
  AST_RET_EXIT: assert property (
    !s.boot && s.pwr_q == PWR_RET && ram_on |=> !s.start)
    else $error("retention exit started the sweep");
  AST_STRAP: assert property (
    s.boot && I_AUTO_INV_DIS |=> s.skip ##1 (O_INV_DONE && !O_INV_VALID))
    else $error("disabled sweep still ran");
  AST_ALLOC_ACT: assert property (
    !I_DC_ACT |=> !O_D_LOOKUP && !O_D_ALLOC)
    else $error("inactive data cache still used");
  AST_EN_OFF: assert property (
    use_ok && I_DC_ACT && !I_DC_EN |=> O_D_LOOKUP && !O_D_ALLOC)
    else $error("disabled cache lookup or allocation wrong");
  AST_SHARED_NC: assert property (
    I_ACC_VALID && !(UNIFIED && I_ACC_FETCH) && I_ACC_SH[SH_SHARED_BIT] |=> !O_ACC_CACHEABLE)
    else $error("shared region treated as cacheable");

  CV_PROMOTE: cover property (O_OP_VALID && O_OP_CODE == dcache_clean_inval_setway_op);
  CV_DSB_STALL: cover property (O_DSB_STALL && O_INV_VALID ##[1:40] O_DSB_DONE);
  CV_DSB_ABORT: cover property (O_DSB_STALL && I_DSB_ABORT);
  CV_CACHEABLE: cover property (O_ACC_VALID && O_ACC_CACHEABLE);
endmodule // l1cm_ctrl

// file: verif/l1cm_ram_model.sv
// cache ram side model: answers each maintenance operation after a set delay
`timescale 1ns/1ps
module l1cm_ram_model (
  input wire logic clk, // core clock
  input wire logic resetn, // synchronous, active low
  input wire logic op_valid, // operation outstanding
  input wire logic [7:0] delay, // cycles before answering
  output logic op_done // one-cycle completion pulse
);
  logic [7:0] cnt;
  // pulse once the count reaches delay, repeated every second cycle while the request stays high
  always_ff @(posedge clk) begin
    if (!resetn || !op_valid) begin
      cnt <= 8'h00;
      op_done <= 1'b0;
    end else if (op_done) begin
      op_done <= 1'b0;
    end else if (cnt >= delay) begin
      op_done <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // l1cm_ram_model

// file: verif/test_l1cm_ctrl.sv
// self-checking bench of the l1 cache maintenance controller
`timescale 1ns/1ps
module test_l1cm_ctrl;
  import l1cm_pkg::*;
  typedef struct {logic [11:0] ofs; logic ns; l1cm_op_t code; logic ic;} l1cm_row_t;
  logic I_CLK = 1'b0, I_RESETN = 1'b0, I_AUTO_INV_DIS = 1'b0, I_CORE_PWR_ON = 1'b1;
  logic [1:0] I_RAM_PWR = PWR_ON, I_MNT_SIZE = SIZE_WORD, I_ACC_SH = 2'h0;
  logic I_MNT_VALID = 1'b0, I_MNT_NS = 1'b0, I_OP_DONE, I_DSB_REQ = 1'b0, I_DSB_ABORT = 1'b0;
  logic [11:0] I_MNT_OFS = 12'h000;
  logic [31:0] I_MNT_WDATA = 32'h0, O_OP_ARG;
  logic I_DC_EN = 1'b1, I_IC_EN = 1'b1, I_DC_ACT = 1'b1, I_IC_ACT = 1'b1;
  logic I_ACC_VALID = 1'b0, I_ACC_FETCH = 1'b0, I_ACC_INNER_C = 1'b0;
  logic O_MNT_READY, O_MNT_ERR, O_OP_VALID, O_OP_ICACHE, O_DSB_STALL, O_DSB_DONE;
  logic O_ACC_VALID, O_ACC_CACHEABLE, O_D_LOOKUP, O_D_ALLOC, O_I_LOOKUP, O_I_ALLOC;
  logic O_INV_VALID, O_INV_DONE, seen, inv_at;
  logic [2:0] O_INV_INDEX;
  logic [1:0] O_INV_I_WAYS;
  logic [3:0] O_INV_D_WAYS;
  l1cm_op_t O_OP_CODE;
  logic [7:0] ram_delay = 8'h00;
  int fail_count = 0, cmp_count = 0, cycles = 0;
  l1cm_row_t rows [13] = '{
    '{12'h000, 1'b0, icache_invalidate_all_op, 1'b1},
    '{12'h004, 1'b0, icache_invalidate_by_addr_op, 1'b1},
    '{12'h008, 1'b0, dcache_invalidate_by_addr_op, 1'b0},
    '{12'h00c, 1'b0, dcache_invalidate_setway_op, 1'b0},
    '{12'h010, 1'b0, dcache_clean_addr_unif_op, 1'b0},
    '{12'h014, 1'b0, dcache_clean_addr_coh_op, 1'b0},
    '{12'h018, 1'b0, dcache_clean_setway_op, 1'b0},
    '{12'h01c, 1'b0, dcache_clean_inval_addr_op, 1'b0},
    '{12'h020, 1'b0, dcache_clean_inval_setway_op, 1'b0},
    '{12'h00c, 1'b1, dcache_clean_inval_setway_op, 1'b0},
    '{12'h008, 1'b1, dcache_clean_inval_addr_op, 1'b0},
    '{12'h000, 1'b1, icache_invalidate_all_op, 1'b1},
    '{12'h004, 1'b1, icache_invalidate_by_addr_op, 1'b1}
  };

  l1cm_ctrl #(.SEC_EXT(1'b1), .UNIFIED(1'b0), .SETS(8)) DUT (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .I_AUTO_INV_DIS(I_AUTO_INV_DIS), .I_CORE_PWR_ON(I_CORE_PWR_ON), .I_RAM_PWR(I_RAM_PWR),
    .I_MNT_VALID(I_MNT_VALID), .I_MNT_OFS(I_MNT_OFS), .I_MNT_SIZE(I_MNT_SIZE), .I_MNT_WDATA(I_MNT_WDATA),
    .I_MNT_NS(I_MNT_NS), .O_MNT_READY(O_MNT_READY), .O_MNT_ERR(O_MNT_ERR), .O_OP_VALID(O_OP_VALID),
    .O_OP_CODE(O_OP_CODE), .O_OP_ICACHE(O_OP_ICACHE), .O_OP_ARG(O_OP_ARG), .I_OP_DONE(I_OP_DONE),
    .I_DSB_REQ(I_DSB_REQ), .I_DSB_ABORT(I_DSB_ABORT), .O_DSB_STALL(O_DSB_STALL), .O_DSB_DONE(O_DSB_DONE),
    .I_DC_EN(I_DC_EN), .I_IC_EN(I_IC_EN), .I_DC_ACT(I_DC_ACT), .I_IC_ACT(I_IC_ACT),
    .I_ACC_VALID(I_ACC_VALID), .I_ACC_FETCH(I_ACC_FETCH), .I_ACC_SH(I_ACC_SH), .I_ACC_INNER_C(I_ACC_INNER_C),
    .O_ACC_VALID(O_ACC_VALID), .O_ACC_CACHEABLE(O_ACC_CACHEABLE), .O_D_LOOKUP(O_D_LOOKUP),
    .O_D_ALLOC(O_D_ALLOC), .O_I_LOOKUP(O_I_LOOKUP), .O_I_ALLOC(O_I_ALLOC), .O_INV_VALID(O_INV_VALID),
    .O_INV_INDEX(O_INV_INDEX), .O_INV_I_WAYS(O_INV_I_WAYS), .O_INV_D_WAYS(O_INV_D_WAYS),
    .O_INV_DONE(O_INV_DONE));

  l1cm_ram_model ram (.clk(I_CLK), .resetn(I_RESETN), .op_valid(O_OP_VALID), .delay(ram_delay),
    .op_done(I_OP_DONE));

  always #10 I_CLK = ~I_CLK;

  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge I_CLK) begin
    cycles++;
    if (cycles >= 3000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one store, held until the edge that samples ready; returns at the next falling edge
  task automatic store(input logic [11:0] ofs, input logic [1:0] size, input logic ns, input logic [31:0] wd);
    I_MNT_VALID = 1'b1;
    I_MNT_OFS = ofs;
    I_MNT_SIZE = size;
    I_MNT_NS = ns;
    I_MNT_WDATA = wd;
    while (O_MNT_READY !== 1'b1) @(negedge I_CLK);
    @(posedge I_CLK);
    @(negedge I_CLK);
    I_MNT_VALID = 1'b0;
  endtask

  task automatic wait_ready;
    for (int n = 0; n < 20 && O_MNT_READY !== 1'b1; n++) @(negedge I_CLK);
    @(negedge I_CLK);
  endtask

  // barrier pulse; records whether it completed and the sweep state at completion
  task automatic barrier;
    I_DSB_REQ = 1'b1;
    @(negedge I_CLK);
    I_DSB_REQ = 1'b0;
    for (int n = 0; n < 40 && O_DSB_DONE !== 1'b1; n++) @(negedge I_CLK);
    seen = O_DSB_DONE;
    inv_at = O_INV_DONE;
  endtask

  initial begin
    repeat (8) @(negedge I_CLK);
    chk(O_MNT_READY, 1'b1);
    chk(O_OP_VALID, 1'b0);
    chk(O_INV_DONE, 1'b0);
    I_RESETN = 1'b1;
    store(12'h00c, SIZE_WORD, 1'b0, 32'h0000_0040);
    chk(O_OP_VALID, 1'b0);
    chk(O_D_LOOKUP, 1'b0);
    barrier();
    chk(seen, 1'b1);
    chk(inv_at, 1'b1);
    for (int i = 0; i < 13; i++) begin
      ram_delay = (i % 2) ? 8'h05 : 8'h00;
      store(rows[i].ofs, SIZE_WORD, rows[i].ns, 32'h2000_0000 + i);
      chk(O_OP_VALID, 1'b1);
      chk(O_OP_CODE, rows[i].code);
      chk(O_OP_ICACHE, rows[i].ic);
      chk(O_OP_ARG, 32'h2000_0000 + i);
      chk(O_MNT_READY, 1'b0);
      wait_ready();
    end
    store(12'h024, SIZE_WORD, 1'b0, 32'h0);
    chk(O_MNT_ERR, 1'b1);
    chk(O_OP_VALID, 1'b0);
    @(negedge I_CLK);
    store(12'h00c, 2'h1, 1'b0, 32'h0);
    chk(O_MNT_ERR, 1'b1);
    @(negedge I_CLK);
    I_DC_ACT = 1'b0;
    store(12'h018, SIZE_WORD, 1'b0, 32'h0);
    chk(O_OP_VALID, 1'b0);
    chk(O_MNT_ERR, 1'b0);
    I_DC_ACT = 1'b1;
    ram_delay = 8'h06;
    store(12'h01c, SIZE_WORD, 1'b0, 32'h0000_1000);
    barrier();
    chk(seen, 1'b1);
    chk(O_OP_VALID, 1'b0);
    wait_ready();
    for (int g = 0; g < 16; g++) begin
      {I_DC_EN, I_IC_EN, I_DC_ACT, I_IC_ACT} = g[3:0];
      @(negedge I_CLK);
      @(negedge I_CLK);
      chk(O_D_LOOKUP, g[1]);
      chk(O_D_ALLOC, g[3] & g[1]);
      chk(O_I_LOOKUP, g[0]);
      chk(O_I_ALLOC, g[2] & g[0]);
    end
    for (int a = 0; a < 8; a++) begin
      I_ACC_VALID = 1'b1;
      I_ACC_SH = a[1:0];
      I_ACC_INNER_C = a[2];
      @(negedge I_CLK);
      I_ACC_VALID = 1'b0;
      chk(O_ACC_VALID, 1'b1);
      chk(O_ACC_CACHEABLE, a[2] & ~a[1]);
    end
    I_RAM_PWR = PWR_RET;
    repeat (3) @(negedge I_CLK);
    I_RAM_PWR = PWR_ON;
    repeat (6) @(negedge I_CLK);
    chk(O_INV_VALID, 1'b0);
    I_RAM_PWR = PWR_OFF;
    repeat (3) @(negedge I_CLK);
    I_RAM_PWR = PWR_ON;
    for (int n = 0; n < 8 && O_INV_VALID !== 1'b1; n++) @(negedge I_CLK);
    for (int k = 0; k < 8; k++) begin
      I_DSB_REQ = (k == 0);
      I_DSB_ABORT = (k == 3);
      chk(O_INV_VALID, 1'b1);
      chk(O_INV_INDEX, k);
      chk({O_D_LOOKUP, O_I_LOOKUP}, 2'h0);
      chk({O_INV_I_WAYS, O_INV_D_WAYS}, 6'h3f);
      if (k == 2) chk(O_DSB_STALL, 1'b1);
      if (k == 5) chk({O_DSB_STALL, O_DSB_DONE}, 2'h0);
      @(negedge I_CLK);
    end
    for (int n = 0; n < 3 && O_INV_DONE !== 1'b1; n++) @(negedge I_CLK);
    chk(O_INV_DONE, 1'b1);
    I_RESETN = 1'b0;
    I_AUTO_INV_DIS = 1'b1;
    repeat (8) @(negedge I_CLK);
    I_RESETN = 1'b1;
    seen = 1'b0;
    repeat (5) begin
      @(negedge I_CLK);
      seen = seen | O_INV_VALID;
    end
    chk(seen, 1'b0);
    chk(O_INV_DONE, 1'b1);
    store(12'h000, SIZE_WORD, 1'b0, 32'h0);
    chk(O_OP_VALID, 1'b1);
    wait_ready();
    complete_run();
  end
endmodule // test_l1cm_ctrl
